// ---- rtl/smrs_defines.svh ----
// offsets, field positions, fault words and timing counts of both link ends
// assumes inclusion by bare name from the two end modules
`ifndef SMRS_DEFINES_SVH
`define SMRS_DEFINES_SVH

// spi slave frame
`define SPI_HDR_BITS        8'd24
`define SPI_DATA_BITS       8'd32
`define SPI_CTRL_WADDR      22'h3c0000
`define SPI_CFGSTAT_WADDR   22'h3c0001
`define SPI_STAT_BIT        16
`define RD_FAULT_WORD       32'h88888888

// management slave window
`define MG_REG_ADDR_LO      5'h00
`define MG_REG_ADDR_HI      5'h01
`define MG_REG_DATA_LO      5'h02
`define MG_REG_DATA_HI      5'h03
`define MG_REG_DATA_INC     5'h04
`define MG_REG_DATA_PAS     5'h05
`define MG_REG_STATUS       5'h06
`define MG_FAULT_HALF       16'h8888
`define MG_PHY_ADDR_A       5'h01
`define MG_PHY_ADDR_B       5'h02
`define MG_FRAME_BITS       8'd64
`define MG_TA_BIT           8'd46
`define MG_DATA_BIT         8'd48

// target access time
`define ACCESS_TIME_NS      1000
`define CORE_CLK_PERIOD_NS  10
`define ACCESS_CYCLES       (`ACCESS_TIME_NS / `CORE_CLK_PERIOD_NS)

// host command port
`define HOST_REG_TARGET     3'h0
`define HOST_REG_WDATA      3'h1
`define HOST_REG_CMD        3'h2
`define HOST_REG_STATUS     3'h3
`define HOST_REG_RDATA      3'h4
`define CMD_SPI_GO          0
`define CMD_MDIO_GO         1
`define CMD_WRITE           2
`define CMD_PAD_LSB         3
`define CMD_BYTE_SWAP       7
`define CMD_LSB_FIRST       8
`endif

// ---- rtl/smrs_pkg.sv ----
// types and the word mapping shared by both link ends
// assumes smrs_defines.svh is on the include path
`default_nettype none
package smrs_pkg;
	typedef enum logic [3:0] {MG_IDLE = 4'b0001, MG_HDR = 4'b0010, MG_TA = 4'b0100, MG_DATA = 4'b1000} mg_state_t;
	typedef enum logic [2:0] {H_IDLE = 3'b001, H_SPI = 3'b010, H_MDIO = 3'b100} host_state_t;

	typedef struct packed {
		logic [4:0]  s1;
		logic [4:0]  s2;
		logic        sclk_q;
		logic        mdc_q;
		logic        strap_done;
		logic        mgmt_en;
		logic        strap_sel;
		logic [7:0]  spi_cnt;
		logic        spi_rw;
		logic [21:0] spi_addr;
		logic [31:0] spi_sh;
		logic [31:0] spi_tx;
		logic        spi_oe;
		logic        spi_do;
		logic        byte_swap;
		logic        lsb_first;
		logic [3:0]  pad;
		logic        pad_stat;
		logic        spi_req;
		logic        spi_rdy;
		logic [31:0] spi_rdat;
		mg_state_t   m_state;
		logic        m_one;
		logic [3:0]  m_cnt;
		logic [12:0] m_hdr;
		logic [15:0] m_sh;
		logic        m_rd;
		logic        m_hit;
		logic        m_oe;
		logic        m_do;
		logic [31:0] addr;
		logic [31:0] data;
		logic        busy;
		logic        busy_rd;
		logic        err;
		logic        mg_req;
		logic        m_we;
		logic        m_inc;
		logic        c_req;
		logic        c_mg;
		logic        c_we;
		logic [7:0]  c_tmo;
		logic [31:0] c_addr;
		logic [31:0] c_wdata;
	} dev_state_t;

	typedef struct packed {
		host_state_t state;
		logic [1:0]  s1;
		logic [1:0]  s2;
		logic        sclk;
		logic        cs_n;
		logic        mosi;
		logic        mdc;
		logic        mdo;
		logic        moe;
		logic [7:0]  ph;
		logic [7:0]  hold;
		logic [7:0]  cnt;
		logic [7:0]  nbits;
		logic [63:0] sh;
		logic [31:0] rx;
		logic [31:0] target;
		logic [31:0] wdata;
		logic [8:0]  cmd;
		logic        busy;
		logic [31:0] rdata;
		logic [31:0] sw_rdata;
	} host_reg_t;

	// byte swap then bit reversal; the mapping is its own inverse
	function automatic logic [31:0] map_word(input logic [31:0] w, input logic byte_swap, input logic lsb_first);
		logic [31:0] t;
		logic [31:0] r;
		t = byte_swap ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
		for (int i = 0; i < 32; i++)
			r[i] = t[31 - i];
		return lsb_first ? r : t;
	endfunction
endpackage
`default_nettype wire

// ---- rtl/smrs_link_if.sv ----
// serial pins between the external host and the register slave
// both pins that can float are pulled high here, the only place levels are resolved
`default_nettype none
interface smrs_link_if;
	logic spi_chip_select_n;
	logic spi_clk;
	logic spi_serial_in;
	logic spi_out_o;
	logic spi_out_oe;
	logic spi_serial_out;
	logic mgmt_slave_clock_pin;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	logic mdio_host_o;
	logic mdio_host_oe;
	logic mgmt_slave_data_pin;

	assign spi_serial_out = spi_out_oe ? spi_out_o : 1'b1;
	assign mgmt_slave_data_pin = mdio_dev_oe ? mdio_dev_o : (mdio_host_oe ? mdio_host_o : 1'b1);

	modport device (input spi_chip_select_n, spi_clk, spi_serial_in, mgmt_slave_clock_pin, mgmt_slave_data_pin,
		output spi_out_o, spi_out_oe, mdio_dev_o, mdio_dev_oe);
	modport host (output spi_chip_select_n, spi_clk, spi_serial_in, mgmt_slave_clock_pin, mdio_host_o, mdio_host_oe,
		input spi_serial_out, mgmt_slave_data_pin);
endinterface
`default_nettype wire

// ---- rtl/smrs_device.sv ----
// device end: spi slave and management-frame slave sharing one core register bus master
// assumes link pins are asynchronous to core_clk and the core target answers with a one-cycle ack
//
// Local design decision: the address-and-strobe port.
`default_nettype none
`include "smrs_defines.svh"
// Behaviour
// - sample input on rising, change output falling
// - drive serial output only during read data
// - frame: rw, spare, 22-bit address, 32 data
// - host masks address to 24 bits, shifts two
// - control bits choose byte and bit order
// - host leaves access time before read data
// - send configured padding bytes before read data
// - late read returns fault pattern, sticky flag
// - control write accepted under any current mapping
// - spi answers only when ownership selects it
// - management frames follow clause 22 format
// - management data sampled and changed on rising
// - answer one of two phy addresses
// - seven 16-bit window registers at 0..6
// - host loads target address halves first
// - high data write launches internal write
// - high data read launches read, returns previous
// - autoinc register also bumps address after completion
// - passive register touches data, launches nothing
// - fault half on error or busy read
// - status: busy, busy at last access, error
// - strap enables management pins takeover
// - core access bounded by access time
module smrs_device
	import smrs_pkg::*;
#(
	parameter int ACCESS_CYCLES = `ACCESS_CYCLES
)(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// serial pins
	smrs_link_if.device      link,
	// configuration
	input  wire logic        spi_slave_owned,
	input  wire logic        mgmt_phy_address_choice,
	input  wire logic [1:0]  boot_strap_pins,
	output var  logic        mgmt_pins_taken,
	// core register bus
	output var  logic        core_req,
	output var  logic        core_we,
	output var  logic [31:0] core_addr,
	output var  logic [31:0] core_wdata,
	input  wire logic        core_ack,
	input  wire logic        core_err,
	input  wire logic [31:0] core_rdata
);
	if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_bad_access
		$error("ACCESS_CYCLES must lie in 1..255");
	end

	// synchronisers start at the pins' idle levels, so no false clock edge follows reset
	localparam dev_state_t DEV_RESET = '{s1: 5'h11, s2: 5'h11, m_state: MG_IDLE, default: '0};

	dev_state_t  q;
	dev_state_t  d;
	logic        cs_on;
	logic        mosi;
	logic        mdin;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        mdc_rise;
	logic [7:0]  first;
	logic [21:0] a_full;
	logic [31:0] raw;
	logic [31:0] tx;
	logic [31:0] rv;
	logic        re;
	logic [12:0] hdr;
	logic [4:0]  reg_sel;
	logic [15:0] mv;
	logic [15:0] wv;

	always_comb
	begin
		d = q;
		d.s1 = {link.spi_chip_select_n, link.spi_clk, link.spi_serial_in, link.mgmt_slave_clock_pin,
			link.mgmt_slave_data_pin};
		d.s2 = q.s1;
		d.sclk_q = q.s2[3];
		d.mdc_q = q.s2[1];
		cs_on = !q.s2[4] && spi_slave_owned;
		mosi = q.s2[2];
		mdin = q.s2[0];
		sclk_rise = q.s2[3] && !q.sclk_q;
		sclk_fall = !q.s2[3] && q.sclk_q;
		mdc_rise = q.s2[1] && !q.mdc_q;
		first = `SPI_HDR_BITS + {1'b0, q.pad, 3'b000};
		a_full = {q.spi_addr[20:0], mosi};
		raw = {q.spi_sh[30:0], mosi};
		tx = '0;
		rv = '0;
		re = 1'b0;
		hdr = {q.m_hdr[11:0], mdin};
		reg_sel = q.m_hdr[4:0];
		wv = {q.m_sh[14:0], mdin};

		// straps are static pins, caught once just after reset release
		if (!q.strap_done)
		begin
			d.strap_done = 1'b1;
			d.mgmt_en = boot_strap_pins[0];
			d.strap_sel = boot_strap_pins[1];
		end

		// core bus: one access at a time, spi first
		if (q.c_req)
		begin
			d.c_tmo = q.c_tmo + 8'h01;
			if (core_ack || q.c_tmo == 8'(ACCESS_CYCLES))
			begin
				d.c_req = 1'b0;
				re = !core_ack || core_err;
				rv = re ? `RD_FAULT_WORD : core_rdata;
				if (q.c_mg)
				begin
					d.data = q.c_we ? q.data : rv;
					d.err = re;
					d.busy = 1'b0;
					if (q.m_inc)
						d.addr = q.addr + 32'h1;
				end
				else
				begin
					d.spi_rdat = rv;
					d.spi_rdy = 1'b1;
				end
			end
		end
		else if (q.spi_req)
		begin
			d.c_req = 1'b1;
			d.c_mg = 1'b0;
			d.c_tmo = '0;
			d.c_we = q.spi_rw;
			d.c_addr = {10'h000, q.spi_addr};
			d.c_wdata = q.spi_rdat;
			d.spi_req = 1'b0;
		end
		else if (q.mg_req)
		begin
			d.c_req = 1'b1;
			d.c_mg = 1'b1;
			d.c_tmo = '0;
			d.c_we = q.m_we;
			d.c_addr = q.addr;
			d.c_wdata = q.data;
			d.mg_req = 1'b0;
		end

		// spi slave
		if (!cs_on)
		begin
			d.spi_cnt = '0;
			d.spi_oe = 1'b0;
			d.spi_req = d.spi_req && q.spi_rw;
		end
		else
		begin
			if (sclk_rise)
			begin
				if (q.spi_cnt != 8'hff)
					d.spi_cnt = q.spi_cnt + 8'h01;
				if (q.spi_cnt == 8'h00)
					d.spi_rw = mosi;
				else if (q.spi_cnt >= 8'h02 && q.spi_cnt < `SPI_HDR_BITS)
					d.spi_addr = a_full;
				else
					d.spi_sh = raw;
				if (q.spi_cnt == `SPI_HDR_BITS - 8'h01 && !q.spi_rw)
				begin
					d.spi_rdy = 1'b0;
					if (a_full == `SPI_CTRL_WADDR)
					begin
						d.spi_rdat = {30'h0, q.lsb_first, q.byte_swap};
						d.spi_rdy = 1'b1;
					end
					else if (a_full == `SPI_CFGSTAT_WADDR)
					begin
						d.spi_rdat = '0;
						d.spi_rdat[`SPI_STAT_BIT] = q.pad_stat;
						d.spi_rdat[3:0] = q.pad;
						d.spi_rdy = 1'b1;
					end
					else
						d.spi_req = 1'b1;
				end
				// write launches only once every bit has arrived
				if (q.spi_cnt == `SPI_HDR_BITS + `SPI_DATA_BITS - 8'h01 && q.spi_rw)
				begin
					if (q.spi_addr == `SPI_CTRL_WADDR)
					begin
						d.byte_swap = raw[0];
						d.lsb_first = raw[1];
					end
					else if (q.spi_addr == `SPI_CFGSTAT_WADDR)
					begin
						tx = map_word(raw, q.byte_swap, q.lsb_first);
						d.pad = tx[3:0];
						if (tx[`SPI_STAT_BIT])
							d.pad_stat = 1'b0;
					end
					else
					begin
						d.spi_rdat = map_word(raw, q.byte_swap, q.lsb_first);
						d.spi_req = 1'b1;
					end
				end
			end
			if (sclk_fall && !q.spi_rw)
			begin
				if (q.spi_cnt == first)
				begin
					// target not done in time: fault word, sticky flag
					tx = map_word(q.spi_rdy ? q.spi_rdat : `RD_FAULT_WORD, q.byte_swap, q.lsb_first);
					if (!q.spi_rdy)
					begin
						d.pad_stat = 1'b1;
						d.spi_req = 1'b0;
					end
					d.spi_oe = 1'b1;
					d.spi_do = tx[31];
					d.spi_tx = {tx[30:0], 1'b0};
				end
				else if (q.spi_cnt > first && q.spi_cnt < first + `SPI_DATA_BITS)
				begin
					d.spi_do = q.spi_tx[31];
					d.spi_tx = {q.spi_tx[30:0], 1'b0};
				end
				else
					d.spi_oe = 1'b0;
			end
		end

		// management slave read value, chosen at turnaround
		case (reg_sel)
			`MG_REG_ADDR_LO:  mv = q.addr[15:0];
			`MG_REG_ADDR_HI:  mv = q.addr[31:16];
			`MG_REG_DATA_LO:  mv = q.data[15:0];
			`MG_REG_DATA_HI,
			`MG_REG_DATA_INC: mv = q.busy ? `MG_FAULT_HALF : q.data[31:16];
			`MG_REG_DATA_PAS: mv = q.data[31:16];
			`MG_REG_STATUS:   mv = {13'h0000, q.err, q.busy_rd, q.busy};
			default:          mv = '0;
		endcase

		if (q.mgmt_en && mdc_rise)
		begin
			case (q.m_state)
				MG_IDLE:
				begin
					d.m_one = mdin;
					if (q.m_one && !mdin)
					begin
						d.m_state = MG_HDR;
						d.m_cnt = '0;
					end
				end
				MG_HDR:
				begin
					d.m_hdr = hdr;
					d.m_cnt = q.m_cnt + 4'h1;
					if (q.m_cnt == 4'hc)
					begin
						d.m_state = MG_TA;
						d.m_cnt = '0;
						d.m_rd = hdr[11:10] == 2'b10;
						d.m_hit = hdr[12] && (hdr[11] != hdr[10]) && hdr[4:0] <= `MG_REG_STATUS
							&& hdr[9:5] == ((q.strap_sel || mgmt_phy_address_choice) ?
							`MG_PHY_ADDR_B : `MG_PHY_ADDR_A);
					end
				end
				MG_TA:
				begin
					if (q.m_cnt == 4'h0)
					begin
						d.m_cnt = 4'h1;
						d.m_oe = q.m_rd && q.m_hit;
						d.m_do = 1'b0;
					end
					else
					begin
						d.m_state = MG_DATA;
						d.m_cnt = '0;
						d.m_do = mv[15];
						d.m_sh = {mv[14:0], 1'b0};
					end
				end
				MG_DATA:
				begin
					d.m_cnt = q.m_cnt + 4'h1;
					d.m_sh = wv;
					d.m_do = q.m_sh[15];
					if (q.m_cnt == 4'hf)
					begin
						d.m_state = MG_IDLE;
						d.m_oe = 1'b0;
						d.m_one = 1'b0;
						if (q.m_hit && !q.m_rd)
						begin
							case (reg_sel)
								`MG_REG_ADDR_LO: d.addr[15:0] = wv;
								`MG_REG_ADDR_HI: d.addr[31:16] = wv;
								`MG_REG_DATA_LO: d.data[15:0] = wv;
								`MG_REG_DATA_HI,
								`MG_REG_DATA_INC,
								`MG_REG_DATA_PAS: d.data[31:16] = wv;
								default: d.data = d.data;
							endcase
						end
						// launch after the frame, so this read returned older data
						if (q.m_hit && (reg_sel == `MG_REG_DATA_HI || reg_sel == `MG_REG_DATA_INC))
						begin
							d.busy_rd = q.busy;
							if (!q.busy)
							begin
								d.mg_req = 1'b1;
								d.busy = 1'b1;
								d.m_we = !q.m_rd;
								d.m_inc = reg_sel == `MG_REG_DATA_INC;
							end
						end
					end
				end
				default: d.m_state = MG_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= DEV_RESET;
		else
			q <= d;
	end

	assign link.spi_out_o = q.spi_do;
	assign link.spi_out_oe = q.spi_oe;
	assign link.mdio_dev_o = q.m_do;
	assign link.mdio_dev_oe = q.m_oe;
	assign mgmt_pins_taken = q.mgmt_en;
	assign core_req = q.c_req;
	assign core_we = q.c_we;
	assign core_addr = q.c_addr;
	assign core_wdata = q.c_wdata;
endmodule // smrs_device
`default_nettype wire

// ---- rtl/smrs_host.sv ----
// host end: software command port driving spi and management frames on the link
// assumes a single software master on core_clk; link clocks are made here by a divider
`default_nettype none
`include "smrs_defines.svh"
module smrs_host
	import smrs_pkg::*;
#(
	parameter int HALF_PERIOD   = 8,
	parameter int ACCESS_CYCLES = `ACCESS_CYCLES
)(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// serial pins
	smrs_link_if.host        link,
	// software port
	input  wire logic [2:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output var  logic [31:0] sw_rdata
);
	// below eight cycles the device's pin synchronisers lag a whole half period
	if (HALF_PERIOD < 8 || HALF_PERIOD > 255 || ACCESS_CYCLES < 1 || ACCESS_CYCLES > 240) begin : g_bad_param
		$error("HALF_PERIOD must lie in 8..255 and ACCESS_CYCLES in 1..240");
	end

	localparam host_reg_t HOST_RESET = '{state: H_IDLE, s1: 2'h3, s2: 2'h3, cs_n: 1'b1, default: '0};

	host_reg_t   q;
	host_reg_t   d;
	logic        wr;
	logic        spi;
	logic        lvl;
	logic [7:0]  rd_first;
	logic [63:0] sh;

	always_comb
	begin
		d = q;
		d.s1 = {link.spi_serial_out, link.mgmt_slave_data_pin};
		d.s2 = q.s1;
		wr = q.cmd[`CMD_WRITE];
		spi = q.state == H_SPI;
		lvl = spi ? q.sclk : q.mdc;
		rd_first = `SPI_HDR_BITS + {1'b0, q.cmd[`CMD_PAD_LSB +: 4], 3'b000};
		sh = '0;

		if (sw_rd)
		begin
			case (sw_addr)
				`HOST_REG_TARGET: d.sw_rdata = q.target;
				`HOST_REG_WDATA:  d.sw_rdata = q.wdata;
				`HOST_REG_CMD:    d.sw_rdata = {23'h0, q.cmd};
				`HOST_REG_STATUS: d.sw_rdata = {31'h0, q.busy};
				`HOST_REG_RDATA:  d.sw_rdata = q.rdata;
				default:          d.sw_rdata = '0;
			endcase
		end

		case (q.state)
			H_IDLE:
			begin
				if (sw_wr && sw_addr == `HOST_REG_TARGET)
					d.target = sw_wdata;
				if (sw_wr && sw_addr == `HOST_REG_WDATA)
					d.wdata = sw_wdata;
				if (sw_wr && sw_addr == `HOST_REG_CMD)
				begin
					d.cmd = sw_wdata[8:0];
					d.cnt = '0;
					d.ph = '0;
					if (sw_wdata[`CMD_SPI_GO])
					begin
						// word address is byte address masked to 24 bits, shifted by two
						sh = {sw_wdata[`CMD_WRITE], 1'b0, q.target[23:2],
							map_word(q.wdata, sw_wdata[`CMD_BYTE_SWAP], sw_wdata[`CMD_LSB_FIRST]), 8'h00};
						d.state = H_SPI;
						d.busy = 1'b1;
						d.cs_n = 1'b0;
						d.nbits = sw_wdata[`CMD_WRITE] ? `SPI_HDR_BITS + `SPI_DATA_BITS :
							`SPI_HDR_BITS + `SPI_DATA_BITS + {1'b0, sw_wdata[`CMD_PAD_LSB +: 4], 3'b000};
						d.mosi = sh[63];
						d.sh = {sh[62:0], 1'b0};
					end
					else if (sw_wdata[`CMD_MDIO_GO])
					begin
						sh = {32'hffffffff, 2'b01, sw_wdata[`CMD_WRITE] ? 2'b01 : 2'b10,
							q.target[9:0], sw_wdata[`CMD_WRITE] ? {2'b10, q.wdata[15:0]} : 18'h3ffff};
						d.state = H_MDIO;
						d.busy = 1'b1;
						d.nbits = `MG_FRAME_BITS;
						d.moe = 1'b1;
						d.mdo = sh[63];
						d.sh = {sh[62:0], 1'b0};
					end
				end
			end
			H_SPI,
			H_MDIO:
			begin
				if (q.hold != 8'h00)
					d.hold = q.hold - 8'h01;
				else if (q.ph == 8'(HALF_PERIOD - 1))
				begin
					d.ph = '0;
					if (!lvl)
					begin
						if (spi)
							d.sclk = 1'b1;
						else
							d.mdc = 1'b1;
						d.cnt = q.cnt + 8'h01;
						if (spi && !wr && q.cnt >= rd_first)
							d.rx = {q.rx[30:0], q.s2[1]};
						if (!spi && !wr && q.cnt >= `MG_DATA_BIT)
							d.rx = {q.rx[30:0], q.s2[0]};
						// no padding: stall the clock for the target's access time plus eight cycles
						if (spi && !wr && q.cnt == `SPI_HDR_BITS - 8'h01 && q.cmd[`CMD_PAD_LSB +: 4] == 4'h0)
							d.hold = 8'(ACCESS_CYCLES + 8);
					end
					else
					begin
						d.sclk = 1'b0;
						d.mdc = 1'b0;
						if (q.cnt == q.nbits)
						begin
							d.state = H_IDLE;
							d.busy = 1'b0;
							d.cs_n = 1'b1;
							d.moe = 1'b0;
							if (!wr)
								d.rdata = spi ? map_word(q.rx, q.cmd[`CMD_BYTE_SWAP], q.cmd[`CMD_LSB_FIRST]) :
									{16'h0000, q.rx[15:0]};
						end
						else
						begin
							d.mosi = q.sh[63];
							d.mdo = q.sh[63];
							d.moe = !spi && (wr || q.cnt < `MG_TA_BIT);
							d.sh = {q.sh[62:0], 1'b0};
						end
					end
				end
				else
					d.ph = q.ph + 8'h01;
			end
			default: d.state = H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= HOST_RESET;
		else
			q <= d;
	end

	assign link.spi_chip_select_n = q.cs_n;
	assign link.spi_clk = q.sclk;
	assign link.spi_serial_in = q.mosi;
	assign link.mgmt_slave_clock_pin = q.mdc;
	assign link.mdio_host_o = q.mdo;
	assign link.mdio_host_oe = q.moe;
	assign sw_rdata = q.sw_rdata;
endmodule // smrs_host
`default_nettype wire

// ---- bench/smrs_link_props.sv ----
// checker on the link pins joining the host end and the device end
// assumes the link signals arrive as plain inputs sampled on core_clk
`default_nettype none
module smrs_link_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// spi pins
	input wire logic spi_chip_select_n,
	input wire logic spi_clk,
	input wire logic spi_out_o,
	input wire logic spi_out_oe,
	// management pins
	input wire logic mgmt_slave_clock_pin,
	input wire logic mdio_dev_o,
	input wire logic mdio_dev_oe,
	input wire logic mdio_host_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_miso_idle: assert property (spi_chip_select_n [*6] |-> !spi_out_oe)
		else $error("miso driven while deselected");
	a_miso_on_fall: assert property (spi_out_oe && $changed(spi_out_o) |-> !spi_clk)
		else $error("miso changed while spi clock high");
	a_miso_start: assert property ($rose(spi_out_oe) |-> !spi_clk && !spi_chip_select_n)
		else $error("miso enabled outside a low clock phase");
	a_miso_stands: assert property ($rose(spi_out_oe) |=> spi_out_oe [*8])
		else $error("miso drive dropped early");
	a_mdio_one_drv: assert property (!(mdio_dev_oe && mdio_host_oe))
		else $error("both ends drive mdio");
	a_mdio_ta_zero: assert property ($rose(mdio_dev_oe) |-> !mdio_dev_o && mgmt_slave_clock_pin)
		else $error("turnaround bit not zero");
	a_mdio_on_rise: assert property (mdio_dev_oe && $changed(mdio_dev_o) |-> mgmt_slave_clock_pin)
		else $error("mdio changed while clock low");
	a_mdio_stands: assert property ($rose(mdio_dev_oe) |=> mdio_dev_oe [*8])
		else $error("mdio drive dropped early");

	cover property ($rose(spi_out_oe));
	cover property ($rose(mdio_dev_oe));
	cover property ($fell(spi_chip_select_n));
endmodule // smrs_link_props
`default_nettype wire

// ---- bench/test_serial_mgmt_register_slave.sv ----
// bench joining both link ends, with a core target model on the device
// assumes the host end keeps the software port contract of its note
`default_nettype none
module test_serial_mgmt_register_slave;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        reset_n, owned, pins, core_req, core_we, core_ack, core_err;
	logic [31:0] core_addr, core_wdata, core_rdata, rd_val, last_a, last_d, sw_wdata, sw_rdata, d;
	logic [2:0]  sw_addr;
	logic        sw_wr, sw_rd, err_en, last_w, phy_b, host_rst_n;
	logic [7:0]  dly, cnt;
	int          fails, n_checks, n_req, cyc;

	smrs_link_if link ();
	// host waits less than the device so a slow target shows up as late
	// host has its own reset so a frame can be cut in mid-flight
	smrs_host #(.ACCESS_CYCLES(20)) i_smrs_host (.core_clk(core_clk), .reset_n(host_rst_n), .link(link),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	smrs_device i_smrs_device (.core_clk(core_clk), .reset_n(reset_n), .link(link),
		.spi_slave_owned(owned), .mgmt_phy_address_choice(phy_b), .boot_strap_pins(2'b01),
		.mgmt_pins_taken(pins), .core_req(core_req), .core_we(core_we), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_ack(core_ack), .core_err(core_err), .core_rdata(core_rdata));
	smrs_link_props i_props (.core_clk(core_clk), .reset_n(reset_n),
		.spi_chip_select_n(link.spi_chip_select_n), .spi_clk(link.spi_clk), .spi_out_o(link.spi_out_o),
		.spi_out_oe(link.spi_out_oe), .mgmt_slave_clock_pin(link.mgmt_slave_clock_pin),
		.mdio_dev_o(link.mdio_dev_o), .mdio_dev_oe(link.mdio_dev_oe), .mdio_host_oe(link.mdio_host_oe));

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end

	// core target: answers dly+1 cycles after a request
	always @(posedge core_clk)
	begin
		core_ack <= 1'b0;
		core_rdata <= rd_val;
		core_err <= err_en;
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fails++;
			wrap_up;
		end
		if (core_req && !core_ack)
		begin
			cnt <= cnt + 8'h1;
			if (cnt == dly)
			begin
				core_ack <= 1'b1;
				cnt <= 8'h0;
				last_a <= core_addr;
				last_d <= core_wdata;
				last_w <= core_we;
				n_req <= n_req + 1;
			end
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// strobes drop one edge before the next request so no signal is set twice at once
	task automatic sw_w(input logic [2:0] a, input logic [31:0] v);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic sw_r(input logic [2:0] a, output logic [31:0] v);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
		@(posedge core_clk);
	endtask

	task automatic go(input logic [31:0] c);
		logic [31:0] s;
		s = 32'h1;
		sw_w(3'h2, c);
		for (int i = 0; i < 3000 && s[0] !== 1'b0; i++)
			sw_r(3'h3, s);
		chk({31'h0, s[0]}, 32'h0);
	endtask

	task automatic settle(input int n0);
		for (int i = 0; i < 60 && n_req == n0; i++)
			@(posedge core_clk);
	endtask

	task automatic spi(input logic wr, input logic [31:0] ba, input logic [31:0] v, input logic [31:0] c);
		int n0;
		n0 = n_req;
		sw_w(3'h0, ba);
		sw_w(3'h1, v);
		go(c | {29'h0, wr, 2'h1});
		settle(n0);
		sw_r(3'h4, d);
	endtask

	task automatic mw(input logic [4:0] phy, input logic [4:0] r, input logic [31:0] v);
		sw_w(3'h0, {22'h0, phy, r});
		sw_w(3'h1, v);
		go(32'h6);
	endtask

	task automatic mr(input logic [4:0] r);
		sw_w(3'h0, {22'h0, 5'h01, r});
		go(32'h2);
		sw_r(3'h4, d);
		d = d & 32'hffff;
	endtask

	task automatic t_spi;
		int n0;
		spi(1'b1, 32'h5f001234, 32'hdeadbeef, 32'h0);
		chk(last_a, 32'h0000048d);
		chk(last_d, 32'hdeadbeef);
		chk({31'h0, last_w}, 32'h1);
		rd_val = 32'h12345678;
		spi(1'b0, 32'h00000010, 32'h0, 32'h0);
		chk(d, 32'h12345678);
		chk(last_a, 32'h00000004);
		chk({31'h0, last_w}, 32'h0);
		// byte-swap control word is the same under every mapping
		spi(1'b1, 32'h00f00000, 32'h81818181, 32'h0);
		spi(1'b1, 32'h00000020, 32'h11223344, 32'h0);
		chk(last_d, 32'h44332211);
		spi(1'b1, 32'h00f00000, 32'h0, 32'h0);
		dly = 8'd60;
		spi(1'b0, 32'h00000030, 32'h0, 32'h0);
		chk(d, 32'h88888888);
		dly = 8'd5;
		spi(1'b0, 32'h00f00004, 32'h0, 32'h0);
		chk(d & 32'h10000, 32'h10000);
		// one padding byte covers a slow target without pausing the clock
		spi(1'b1, 32'h00f00004, 32'h00010001, 32'h0);
		dly = 8'd60;
		rd_val = 32'h5a6b7c8d;
		spi(1'b0, 32'h00000070, 32'h0, 32'h8);
		chk(d, 32'h5a6b7c8d);
		spi(1'b0, 32'h00f00004, 32'h0, 32'h8);
		chk(d, 32'h00000001);
		spi(1'b1, 32'h00f00004, 32'h0, 32'h0);
		dly = 8'd5;
		owned <= 1'b0;
		n0 = n_req;
		spi(1'b1, 32'h00000040, 32'h1, 32'h0);
		chk(n_req, n0);
		chk(last_a, 32'h0000001c);
		owned <= 1'b1;
	endtask

	task automatic t_cut;
		int n0;
		n0 = n_req;
		sw_w(3'h0, 32'h00000050);
		sw_w(3'h2, 32'h5);
		// a few bits into the data, well before the last one
		repeat (500) @(posedge core_clk);
		host_rst_n <= 1'b0;
		@(posedge core_clk);
		host_rst_n <= 1'b1;
		settle(n0);
		chk(n_req, n0);
		spi(1'b1, 32'h00000060, 32'ha5a5a5a5, 32'h0);
		chk(last_a, 32'h00000018);
		chk(last_d, 32'ha5a5a5a5);
	endtask

	task automatic t_mgmt;
		int n0;
		mw(5'h01, 5'h0, 32'h0abc);
		mw(5'h01, 5'h1, 32'h0001);
		n0 = n_req;
		mw(5'h01, 5'h2, 32'h5566);
		settle(n0);
		chk(n_req, n0);
		mw(5'h01, 5'h3, 32'h7788);
		mr(5'h6);
		chk(last_a, 32'h00010abc);
		chk(last_d, 32'h77885566);
		chk({31'h0, last_w}, 32'h1);
		rd_val = 32'hcafef00d;
		mr(5'h4);
		chk(d, 32'h7788);
		mr(5'h6);
		n0 = n_req;
		mr(5'h5);
		chk(d, 32'hcafe);
		settle(n0);
		chk(n_req, n0);
		mr(5'h2);
		chk(d, 32'hf00d);
		mr(5'h3);
		chk(d, 32'hcafe);
		mr(5'h6);
		chk(d, 32'h0);
		chk(last_a, 32'h00010abd);
		err_en = 1'b1;
		mr(5'h3);
		mr(5'h6);
		chk(d, 32'h4);
		mr(5'h2);
		chk(d, 32'h8888);
		err_en = 1'b0;
		n0 = n_req;
		mw(5'h03, 5'h3, 32'h1);
		settle(n0);
		chk(n_req, n0);
		phy_b <= 1'b1;
		mw(5'h01, 5'h0, 32'h1111);
		mw(5'h02, 5'h1, 32'h2222);
		phy_b <= 1'b0;
		mr(5'h0);
		chk(d, 32'h0abd);
		mr(5'h1);
		chk(d, 32'h2222);
	endtask

	initial
	begin
		{reset_n, sw_wr, sw_rd, core_ack, core_err, err_en, cnt, cyc, n_req} = '0;
		{sw_addr, sw_wdata, core_rdata, rd_val, host_rst_n, phy_b} = '0;
		owned = 1'b1;
		dly = 8'd5;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		host_rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({31'h0, pins}, 32'h1);
		t_spi;
		t_cut;
		t_mgmt;
		wrap_up;
	end
endmodule // test_serial_mgmt_register_slave
`default_nettype wire
